// >>> inc/lpswc_pkg.sv
// Constants and types shared by the power-state wake controller
package lpswc_pkg;
   // Bus geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   // Number of wake-up pins
   localparam int NPIN = 5;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_LEVEL = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_ENABLE = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_CMD = 5'h0c;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STS = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MSK = 5'h18;
   localparam logic [ADDR_W-1:0] OFF_WAKE_SRC = 5'h1c;
   // Reset values
   localparam logic [NPIN-1:0] RST_LEVEL = 5'h00;
   localparam logic [NPIN-1:0] RST_ENABLE = 5'h07;
   localparam logic [2:0] RST_CTRL = 3'h0;
   localparam logic [2:0] RST_IRQ = 3'h0;
   localparam logic [2:0] RST_PULLUP = 3'h7;
   // Control register fields
   localparam int CTRL_XO32 = 0;
   localparam int CTRL_BANK1_RET = 1;
   localparam int CTRL_XO32_DONE = 2;
   // Command register fields
   localparam int CMD_STANDBY = 0;
   localparam int CMD_SLEEP = 1;
   // Interrupt status fields
   localparam int IRQ_PIN_WAKE = 0;
   localparam int IRQ_TMR_WAKE = 1;
   localparam int IRQ_ACTIVE = 2;
   // Status register field positions
   localparam int STS_STATE_LSB = 0;
   localparam int STS_HF_XO = 4;
   localparam int STS_LF_ON = 5;
   // Timing
   localparam int CLK_MHZ = 50;
   localparam int WAKE_LAT_US = 200;
   localparam int WAKE_LAT_CYC = WAKE_LAT_US * CLK_MHZ;
   localparam int LAT_W = 16;
   // Power states
   typedef enum logic [2:0] {
      ST_PREACTIVE,
      ST_ACTIVE,
      ST_STANDBY,
      ST_SLEEP,
      ST_WAKING
   } lpswc_state_e;
endpackage

// >>> logic/lpswc_wake_det.sv
// Per-pin wake-up match on enable and level
`timescale 1ns/1ns
module lpswc_wake_det
   import lpswc_pkg::*;
#(
   parameter int N = NPIN
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Pins and settings
   input wire logic [N-1:0] i_pin,
   input wire logic [N-1:0] i_level,
   input wire logic [N-1:0] i_enable,
   // Registered matches
   output logic [N-1:0] o_hit
);
   // Combinational match per pin
   logic [N-1:0] match;
   // Registered match vector
   logic [N-1:0] hit_r;

   // One comparator per pin
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pin
         // Enabled pin at its selected level
         assign match[g] = i_enable[g] & (i_pin[g] == i_level[g]); // see RL14 see RL15
      end
   endgenerate

   // Register the matches
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         hit_r <= '0;
      end else begin
         hit_r <= match;
      end
   end

   assign o_hit = hit_r;
endmodule // lpswc_wake_det

// >>> logic/lpswc_lat_timer.sv
// Wake-up latency down counter
`timescale 1ns/1ns
module lpswc_lat_timer
   import lpswc_pkg::*;
#(
   parameter int W = LAT_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Start with a load value
   input wire logic i_start,
   input wire logic [W-1:0] i_load,
   // Expiry pulse
   output logic o_done
);
   // Remaining cycles
   logic [W-1:0] cnt_r;
   // Counting flag
   logic run_r;
   // Expiry pulse register
   logic done_r;
   // Last counting cycle
   wire last = run_r && (cnt_r == {{(W-1){1'b0}}, 1'b1});

   // Count down after start
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= last;
         if (i_start) begin
            cnt_r <= i_load;
            run_r <= 1'b1;
         end else if (run_r) begin
            cnt_r <= cnt_r - 1'b1;
            run_r <= !last;
         end
      end
   end

   assign o_done = done_r;
endmodule // lpswc_lat_timer

// >>> logic/lpswc_ctrl.sv
// Power-state sequencer with wake-up control and Avalon-MM registers
//
// Contract
// RL1: Reset enters preactive; leave only when supplies stable
// RL2: Preactive: internal RC 16 MHz and 32.768 kHz
// RL3: Active uses crystal; fast ring oscillator off
// RL4: Software programs extra setup for 32 MHz crystal
// RL5: Standby keeps only RAM retention supplies
// RL6: Standby wakes only on enabled wake pins
// RL7: Sleep keeps retention plus low-frequency oscillator
// RL8: Sleep wakes on pins or radio timer
// RL9: External party drives enabled pins to idle
// RL10: First three pins have default internal pull-ups
// RL11: Pins four and five need external drive
// RL12: Bank zero always retained; bank one selectable
// RL13: Wake-up to resumed operation takes 200 us
// RL14: Level bit per pin: zero low, one high
// RL15: Enable bit per pin, reset value 0x07
// RL16: Wake passes through preactive before active
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ns
module lpswc_ctrl
   import lpswc_pkg::*;
#(
   parameter int WAKE_CYC = WAKE_LAT_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [DATA_W-1:0] i_avs_writedata,
   output logic [DATA_W-1:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   // Analog and oscillator status
   input wire logic i_supplies_stable,
   input wire logic i_xo_ready,
   // Wake sources
   input wire logic [NPIN-1:0] i_wake_pin,
   input wire logic i_radio_timer_evt,
   // Supply and clock controls
   output logic o_main_supply_en,
   output logic o_ret_supply_en,
   output logic o_bank0_ret,
   output logic o_bank1_ret,
   output logic o_ro16_en,
   output logic o_xo_en,
   output logic o_hf_sel_xo,
   output logic o_lf_osc_en,
   output logic [2:0] o_pullup_en,
   // State and interrupt
   output logic [2:0] o_state,
   output logic o_irq
);
   // Wake latency load value
   localparam logic [LAT_W-1:0] WAKE_LOAD = LAT_W'(WAKE_CYC);

   // Register bus select helper
   function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      sel = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
   endfunction

   // Power state
   lpswc_state_e state_r, state_nxt;
   // Software registers
   logic [NPIN-1:0] level_r;
   logic [NPIN-1:0] enable_r;
   logic [2:0] ctrl_r;
   logic [2:0] irq_sts_r, irq_sts_nxt;
   logic [2:0] irq_msk_r;
   // Last wake cause captured at wake
   logic [NPIN:0] wake_src_r;
   // Pending low-power request from software
   logic [1:0] lp_req_r;
   // Bus handshake registers
   logic wait_r;
   logic [DATA_W-1:0] rdata_r;
   // Output registers
   logic main_r, ret_r, bank1_r, ro_r, xo_r, hfxo_r, lf_r, irq_r;
   logic [2:0] pullup_r;
   // Wake detector result
   logic [NPIN-1:0] pin_hit;
   // Latency timer expiry
   logic lat_done;

   // Bus decode
   wire req = i_avs_read | i_avs_write;
   wire acc = req & wait_r;
   wire wr_ok = i_avs_write & !wait_r;
   wire wr_level = wr_ok & sel(i_avs_address, OFF_LEVEL);
   wire wr_enable = wr_ok & sel(i_avs_address, OFF_ENABLE);
   wire wr_ctrl = wr_ok & sel(i_avs_address, OFF_CTRL);
   wire wr_cmd = wr_ok & sel(i_avs_address, OFF_CMD);
   wire wr_ists = wr_ok & sel(i_avs_address, OFF_IRQ_STS);
   wire wr_imsk = wr_ok & sel(i_avs_address, OFF_IRQ_MSK);

   // Wake conditions per state
   wire any_pin = |pin_hit;
   wire standby_wake = any_pin; // see RL6
   wire sleep_wake = any_pin | i_radio_timer_evt; // see RL8
   wire in_standby = (state_r == ST_STANDBY);
   wire in_sleep = (state_r == ST_SLEEP);
   wire wake_now = (in_standby & standby_wake) | (in_sleep & sleep_wake);
   // Crystal switch allowed; 32 MHz needs software setup done
   wire xo_ok = i_xo_ready & (!ctrl_r[CTRL_XO32] | ctrl_r[CTRL_XO32_DONE]); // see RL4
   // Low-power commands in the current write
   wire [1:0] cmd_bits = wr_cmd ? i_avs_writedata[1:0] : 2'h0;

   // Status word
   wire [DATA_W-1:0] status_word = (DATA_W'(state_r) << STS_STATE_LSB) | (DATA_W'(hfxo_r) << STS_HF_XO) |
      (DATA_W'(lf_r) << STS_LF_ON);

   // Read mux, unmapped reads return zero
   wire [DATA_W-1:0] rd_mux =
      sel(i_avs_address, OFF_LEVEL) ? {27'h0, level_r} :
      sel(i_avs_address, OFF_ENABLE) ? {27'h0, enable_r} :
      sel(i_avs_address, OFF_CTRL) ? {29'h0, ctrl_r} :
      sel(i_avs_address, OFF_STATUS) ? status_word :
      sel(i_avs_address, OFF_IRQ_STS) ? {29'h0, irq_sts_r} :
      sel(i_avs_address, OFF_IRQ_MSK) ? {29'h0, irq_msk_r} :
      sel(i_avs_address, OFF_WAKE_SRC) ? {26'h0, wake_src_r} :
      32'h0;

   // Events feeding the sticky flags
   wire [2:0] evt;
   assign evt[IRQ_PIN_WAKE] = wake_now & any_pin;
   assign evt[IRQ_TMR_WAKE] = in_sleep & i_radio_timer_evt;
   assign evt[IRQ_ACTIVE] = (state_r != ST_ACTIVE) & (state_nxt == ST_ACTIVE);

   // Pin wake detector
   lpswc_wake_det #(
      .N(NPIN)
   ) u_det (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(i_wake_pin),
      .i_level(level_r),
      .i_enable(enable_r),
      .o_hit(pin_hit)
   );

   // Wake-up latency timer
   lpswc_lat_timer #(
      .W(LAT_W)
   ) u_lat (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_start(wake_now),
      .i_load(WAKE_LOAD),
      .o_done(lat_done)
   );

   // Next state
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         // Stay until supplies stable and crystal usable
         ST_PREACTIVE: begin
            if (i_supplies_stable && xo_ok) begin // see RL1 see RL16
               state_nxt = ST_ACTIVE;
            end
         end
         // Software requests a low-power state
         ST_ACTIVE: begin
            if (lp_req_r[CMD_SLEEP]) begin
               state_nxt = ST_SLEEP;
            end else if (lp_req_r[CMD_STANDBY]) begin
               state_nxt = ST_STANDBY;
            end
         end
         // Only enabled pins wake standby
         ST_STANDBY: begin
            if (standby_wake) begin // see RL6
               state_nxt = ST_WAKING;
            end
         end
         // Pins or radio timer wake sleep
         ST_SLEEP: begin
            if (sleep_wake) begin // see RL8
               state_nxt = ST_WAKING;
            end
         end
         // Wait out the wake latency, then preactive
         ST_WAKING: begin
            if (lat_done) begin // see RL13
               state_nxt = ST_PREACTIVE; // see RL16
            end
         end
         default: begin
            state_nxt = ST_PREACTIVE;
         end
      endcase
   end

   // Sticky flags, set wins over write-one clear
   assign irq_sts_nxt = (irq_sts_r & ~(wr_ists ? i_avs_writedata[2:0] : 3'h0)) | evt;

   // State register
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_r <= ST_PREACTIVE; // see RL1
      end else begin
         state_r <= state_nxt;
      end
   end

   // Bus handshake: one wait cycle per access
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wait_r <= 1'b1;
         rdata_r <= '0;
      end else begin
         wait_r <= !acc;
         if (acc) begin
            rdata_r <= i_avs_read ? rd_mux : 32'h0;
         end
      end
   end

   // Wake level and enable fields
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         level_r <= RST_LEVEL;
         enable_r <= RST_ENABLE; // see RL15
      end else begin
         if (wr_level) begin
            level_r <= i_avs_writedata[NPIN-1:0]; // see RL14
         end
         if (wr_enable) begin
            enable_r <= i_avs_writedata[NPIN-1:0]; // see RL15
         end
      end
   end

   // Control, mask and interrupt status
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_r <= RST_CTRL;
         irq_msk_r <= RST_IRQ;
         irq_sts_r <= RST_IRQ;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= i_avs_writedata[2:0];
         end
         if (wr_imsk) begin
            irq_msk_r <= i_avs_writedata[2:0];
         end
         irq_sts_r <= irq_sts_nxt;
      end
   end

   // Low-power request latch, cleared on leaving active
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         lp_req_r <= 2'h0;
      end else if (state_r != ST_ACTIVE) begin
         lp_req_r <= 2'h0;
      end else begin
         lp_req_r <= lp_req_r | cmd_bits;
      end
   end

   // Capture the wake cause
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         wake_src_r <= '0;
      end else if (wake_now) begin
         wake_src_r <= {in_sleep & i_radio_timer_evt, pin_hit};
      end
   end

   // Clock and main supply outputs follow the next state; bank one follows software, retention and pull-ups are fixed
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         main_r <= 1'b0;
         ret_r <= 1'b1;
         bank1_r <= 1'b0;
         ro_r <= 1'b1;
         xo_r <= 1'b0;
         hfxo_r <= 1'b0;
         lf_r <= 1'b1;
         pullup_r <= RST_PULLUP;
         irq_r <= 1'b0;
      end else begin
         // Main digital supplies only outside low power
         main_r <= !((state_nxt == ST_STANDBY) || (state_nxt == ST_SLEEP)); // see RL5
         // Retention supply and bank zero always on
         ret_r <= 1'b1; // see RL12
         // Bank one retention chosen by software
         bank1_r <= ctrl_r[CTRL_BANK1_RET]; // see RL12
         // Ring oscillator only when not on crystal
         ro_r <= (state_nxt == ST_PREACTIVE) || (state_nxt == ST_WAKING); // see RL2 see RL3
         // Crystal runs in preactive to start up, and in active
         xo_r <= (state_nxt == ST_PREACTIVE) || (state_nxt == ST_ACTIVE);
         // High-frequency source is crystal only in active
         hfxo_r <= (state_nxt == ST_ACTIVE); // see RL3
         // Low-frequency oscillator off only in standby
         lf_r <= (state_nxt != ST_STANDBY); // see RL2 see RL5 see RL7
         // Internal pull-ups on the first three pins
         pullup_r <= RST_PULLUP; // see RL10
         // Level interrupt from unmasked sticky flags
         irq_r <= |(irq_sts_nxt & irq_msk_r);
      end
   end

   // Output drive from registers
   assign o_avs_readdata = rdata_r;
   assign o_avs_waitrequest = wait_r;
   assign o_main_supply_en = main_r;
   assign o_ret_supply_en = ret_r;
   assign o_bank0_ret = ret_r;
   assign o_bank1_ret = bank1_r;
   assign o_ro16_en = ro_r;
   assign o_xo_en = xo_r;
   assign o_hf_sel_xo = hfxo_r;
   assign o_lf_osc_en = lf_r;
   assign o_pullup_en = pullup_r;
   assign o_state = state_r;
   assign o_irq = irq_r;
endmodule // lpswc_ctrl

// >>> testbench/lpswc_ctrl_properties.sv
// Concurrent checks on the power-state wake controller ports
`timescale 1ns/1ns
module lpswc_ctrl_chk
   import lpswc_pkg::*;
#(
   parameter int WAKE_CYC = WAKE_LAT_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Watched inputs
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic i_supplies_stable,
   input wire logic i_xo_ready,
   input wire logic i_radio_timer_evt,
   // Watched outputs
   input wire logic o_avs_waitrequest,
   input wire logic o_main_supply_en,
   input wire logic o_ret_supply_en,
   input wire logic o_bank0_ret,
   input wire logic o_ro16_en,
   input wire logic o_xo_en,
   input wire logic o_hf_sel_xo,
   input wire logic o_lf_osc_en,
   input wire logic [2:0] o_pullup_en,
   input wire logic [2:0] o_state
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   logic [15:0] wk_cnt_r; // Cycles spent waking
   // Count waking cycles
   always_ff @(posedge i_clk) begin
      if (i_rst || o_state != 3'h4) wk_cnt_r <= 16'h0;
      else wk_cnt_r <= wk_cnt_r + 16'h1;
   end
   a_reset_preactive: assert property ($past(i_rst) |-> o_state == 3'h0 && o_avs_waitrequest)
      else $error("not preactive after reset");
   a_enter_active: assert property ($past(o_state) != 3'h1 && o_state == 3'h1 |->
      $past(o_state) == 3'h0 && $past(i_supplies_stable) && $past(i_xo_ready)) else $error("bad entry to active");
   a_preact_clocks: assert property (o_state == 3'h0 |-> o_ro16_en && !o_hf_sel_xo && o_lf_osc_en)
      else $error("preactive clocks wrong");
   a_active_clocks: assert property (o_state == 3'h1 |-> o_hf_sel_xo && o_xo_en && !o_ro16_en && o_main_supply_en)
      else $error("active clocks wrong");
   a_standby_power: assert property (o_state == 3'h2 |-> !o_main_supply_en && !o_lf_osc_en && !o_ro16_en && !o_xo_en)
      else $error("standby supplies wrong");
   a_sleep_lf: assert property (o_state == 3'h3 |-> o_lf_osc_en && !o_main_supply_en && !o_xo_en)
      else $error("sleep supplies wrong");
   a_retain_bank0: assert property (o_bank0_ret && o_ret_supply_en)
      else $error("bank zero retention lost");
   a_pullup_dflt: assert property (o_pullup_en == 3'h7)
      else $error("pull-ups wrong");
   a_lowpwr_exit: assert property ($past(o_state) inside {3'h2, 3'h3} && !(o_state inside {3'h2, 3'h3}) |->
      o_state == 3'h4) else $error("low power left without waking");
   a_timer_wake: assert property (o_state == 3'h3 && i_radio_timer_evt |=> o_state == 3'h4)
      else $error("timer did not wake sleep");
   a_wake_path: assert property (o_state == 3'h4 |=> o_state == 3'h4 || o_state == 3'h0)
      else $error("waking not followed by preactive");
   a_wake_latency: assert property ($past(o_state) == 3'h4 && o_state != 3'h4 |->
      $past(wk_cnt_r) >= WAKE_CYC - 1 && $past(wk_cnt_r) <= WAKE_CYC + 1) else $error("wake latency wrong");
   a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low too long");
   a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
      else $error("bus answer late");
   c_sleep_wake: cover property (o_state == 3'h3 ##1 o_state == 3'h4);
   c_standby_wake: cover property (o_state == 3'h2 ##1 o_state == 3'h4);
   c_active: cover property ($rose(o_hf_sel_xo));
endmodule // lpswc_ctrl_chk

bind lpswc_ctrl lpswc_ctrl_chk #(.WAKE_CYC(WAKE_CYC)) chk_u (.i_clk(i_clk), .i_rst(i_rst),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_supplies_stable(i_supplies_stable),
   .i_xo_ready(i_xo_ready), .i_radio_timer_evt(i_radio_timer_evt), .o_avs_waitrequest(o_avs_waitrequest),
   .o_main_supply_en(o_main_supply_en), .o_ret_supply_en(o_ret_supply_en), .o_bank0_ret(o_bank0_ret),
   .o_ro16_en(o_ro16_en), .o_xo_en(o_xo_en), .o_hf_sel_xo(o_hf_sel_xo), .o_lf_osc_en(o_lf_osc_en),
   .o_pullup_en(o_pullup_en), .o_state(o_state));

// >>> testbench/lpswc_wake_model.sv
// Model of the external wake pin drivers and radio timer
`timescale 1ns/1ns
module lpswc_wake_model (
   // Clock
   input wire logic i_clk,
   // Requests from the bench
   input wire logic [4:0] i_drive,
   input wire logic [4:0] i_value,
   input wire logic i_tmr_req,
   // Pins and timer event
   output logic [4:0] o_pin,
   output logic o_tmr_evt
);
   logic tgl_r = 1'h0; // Pattern on floating pins
   // Floating pins change every cycle
   always_ff @(posedge i_clk) begin
      tgl_r <= ~tgl_r;
   end
   // Driven pins hold the chosen level; pins 0..2 pull up, 3..4 float
   assign o_pin = (i_drive & i_value) | (~i_drive & {tgl_r, tgl_r, 3'h7});
   assign o_tmr_evt = i_tmr_req;
endmodule // lpswc_wake_model

// >>> testbench/lpswc_ctrl_tb_top.sv
// Self-checking bench for the power-state wake controller
`timescale 1ns/1ns
module lpswc_ctrl_tb_top;
   import lpswc_pkg::*;
   localparam int WCYC = 20; // Short wake latency
   logic i_clk = 1'h0;
   logic i_rst = 1'h1;
   logic [ADDR_W-1:0] adr = 5'h0; // Bus address
   logic rd_en = 1'h0; // Bus read
   logic wr_en = 1'h0; // Bus write
   logic [DATA_W-1:0] wdat = 32'h0; // Bus write data
   logic sup = 1'h0; // Supplies stable
   logic xo = 1'h0; // Crystal ready
   logic [4:0] drv = 5'h0; // Pins driven by the bench
   logic [4:0] val = 5'h0; // Level on driven pins
   logic tmr = 1'h0; // Timer request
   logic [31:0] r; // Random word
   logic [31:0] exp_q[$]; // Expected read data
   int n_errors = 0;
   int tests_run = 0;
   wire [4:0] pin;
   wire tmr_evt;
   wire [DATA_W-1:0] rdata;
   wire wreq;
   wire bank1;
   wire lf_on;
   wire [2:0] st;
   wire irq;
   // Far side
   lpswc_wake_model pm_u (.i_clk(i_clk), .i_drive(drv), .i_value(val), .i_tmr_req(tmr), .o_pin(pin),
      .o_tmr_evt(tmr_evt));
   // Design
   lpswc_ctrl #(.WAKE_CYC(WCYC)) dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr),
      .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdat), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wreq), .i_supplies_stable(sup), .i_xo_ready(xo), .i_wake_pin(pin),
      .i_radio_timer_evt(tmr_evt), .o_main_supply_en(), .o_ret_supply_en(), .o_bank0_ret(),
      .o_bank1_ret(bank1), .o_ro16_en(), .o_xo_en(), .o_hf_sel_xo(), .o_lf_osc_en(lf_on),
      .o_pullup_en(), .o_state(st), .o_irq(irq));
   // Clock
   initial begin
      forever #10 i_clk = ~i_clk;
   end
   // Compare seen against expected
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Verdict and end of run
   task automatic close_out();
      if (n_errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // One bus access, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      adr <= a;
      wr_en <= w;
      rd_en <= !w;
      wdat <= d;
      do begin
         @(posedge i_clk);
         n++;
      end while (wreq !== 1'h0 && n < 50);
      if (n >= 50) begin
         n_errors++;
         close_out();
      end
      rd_en <= 1'h0;
      wr_en <= 1'h0;
      @(posedge i_clk);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      bus(1'h1, a, d);
   endtask
   // Note the expected word, then read
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      exp_q.push_back(e);
      bus(1'h0, a, 32'h0);
   endtask
   // Bounded wait for a power state
   task automatic wait_st(input logic [2:0] s);
      int n;
      for (n = 0; n < 200 && st !== s; n++) @(posedge i_clk);
      if (n >= 200) begin
         n_errors++;
         close_out();
      end
   endtask
   // One-cycle timer expiry
   task automatic pulse();
      tmr <= 1'h1;
      @(posedge i_clk);
      tmr <= 1'h0;
   endtask
   // Read data monitor takes the oldest note
   always @(posedge i_clk) begin
      if (rd_en && wreq === 1'h0) chk("readdata", rdata, exp_q.pop_front());
   end
   // Overall hang guard
   initial begin
      repeat (100000) @(posedge i_clk);
      n_errors++;
      close_out();
   end
   // Main sequence
   initial begin
      r = $urandom(32'h856263d8);
      repeat (10) @(posedge i_clk);
      i_rst <= 1'h0;
      rd(OFF_STATUS, 32'h20);
      rd(OFF_ENABLE, 32'h7);
      rd(OFF_LEVEL, 32'h0);
      rd(OFF_CMD, 32'h0);
      wr(OFF_STATUS, 32'hffffffff);
      rd(OFF_STATUS, 32'h20);
      wr(OFF_CTRL, 32'h1);
      sup <= 1'h1;
      xo <= 1'h1;
      repeat (8) @(posedge i_clk);
      rd(OFF_STATUS, 32'h20);
      repeat (4) begin
         r = $urandom;
         wr(OFF_LEVEL, r);
         rd(OFF_LEVEL, {27'h0, r[4:0]});
      end
      wr(OFF_LEVEL, 32'h0);
      wr(OFF_CTRL, 32'h7);
      wait_st(3'h1);
      rd(OFF_STATUS, 32'h31);
      chk("bank1", {31'h0, bank1}, 32'h1);
      wr(OFF_IRQ_STS, 32'h7);
      rd(OFF_IRQ_STS, 32'h0);
      wr(OFF_IRQ_MSK, 32'h7);
      // Sleep wins over standby, timer wakes
      wr(OFF_CMD, 32'h3);
      wait_st(3'h3);
      chk("lf_on", {31'h0, lf_on}, 32'h1);
      pulse();
      wait_st(3'h1);
      rd(OFF_WAKE_SRC, 32'h20);
      rd(OFF_IRQ_STS, 32'h6);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(OFF_IRQ_STS, 32'h6);
      rd(OFF_IRQ_STS, 32'h0);
      chk("irq", {31'h0, irq}, 32'h0);
      // Standby ignores timer and disabled pin
      wr(OFF_IRQ_MSK, 32'h0);
      wr(OFF_CMD, 32'h1);
      wait_st(3'h2);
      pulse();
      drv <= 5'h08;
      repeat (6) @(posedge i_clk);
      chk("state", {29'h0, st}, 32'h2);
      drv <= 5'h09;
      wait_st(3'h4);
      drv <= 5'h0;
      wait_st(3'h1);
      rd(OFF_WAKE_SRC, 32'h1);
      rd(OFF_IRQ_STS, 32'h5);
      chk("irq", {31'h0, irq}, 32'h0);
      // High-level wake on the fifth pin from sleep, 16 MHz crystal, bank one dropped
      wr(OFF_LEVEL, 32'h10);
      wr(OFF_ENABLE, 32'h10);
      wr(OFF_CTRL, 32'h0);
      drv <= 5'h10;
      wr(OFF_CMD, 32'h2);
      wait_st(3'h3);
      xo <= 1'h0;
      val <= 5'h10;
      wait_st(3'h4);
      val <= 5'h0;
      // Preactive holds until the crystal is ready
      wait_st(3'h0);
      repeat (4) @(posedge i_clk);
      rd(OFF_STATUS, 32'h20);
      xo <= 1'h1;
      wait_st(3'h1);
      rd(OFF_WAKE_SRC, 32'h10);
      chk("bank1", {31'h0, bank1}, 32'h0);
      close_out();
   end
endmodule // lpswc_ctrl_tb_top
